// >>> src/timer16_core.sv
// sixteen_bit_timer core: counter, compare shadows, outputs, apb registers
`include "timer16_params.svh"

module timer16_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_event_input,
    output logic [3:0] timer_output,
    output logic [3:0] channel_match_irq,
    output logic overflow_irq
);
    import timer16_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] timer_control_0; // run enable, prescale select
    logic [7:0] timer_control_1; // external clock enable, mode
    logic [7:0] timer_output_control; // enable and idle level pairs
    logic [7:0] capture_input_control; // capture edge select
    logic [7:0] event_trigger_edge_select; // event and trigger edges
    logic overflow_flag; // sticky overflow
    count_type compare_reg [0:3]; // software compare words
    count_type shadow [0:3]; // values the counter is compared with
    count_type counter; // live count
    logic started; // first count clock after start taken
    logic batch_pending; // channel 1 written since last transfer
    logic captured_ones; // last capture-clear held all-ones
    logic [7:0] prescale; // internal clock divider
    logic [3:0] toggle_state; // toggle flop per output

    // ****************************************************************
    // decoded controls
    // ****************************************************************
    logic timer_run_enable; // timer running
    logic external_clock_enable; // count on event edges
    mode_type mode; // operating mode
    logic batch_mode; // deferred shadow transfer
    logic clear_on_match; // counter cleared by channel-0 match
    logic overflow_mode; // wraps count as overflow
    logic event_edge; // valid edge of the event input
    logic capture_edge; // valid edge of the capture trigger
    logic internal_tick; // prescaled count enable
    logic tick; // count clock enable
    logic [7:0] prescale_mask; // divider terminal bits
    logic [3:0] match; // counter equals shadow on a tick
    logic period_clear; // channel-0 match that clears
    logic capture_clear; // capture that clears the counter
    logic wrap; // all-ones to zero without a clear
    logic start_tick; // first tick after run enable
    logic access; // apb access phase edge
    logic wr_en; // write takes effect
    logic addr_ok; // address is mapped
    logic [31:0] next_rdata; // read mux

    assign timer_run_enable = timer_control_0[`POS_RUN_ENABLE];
    assign external_clock_enable = timer_control_1[`POS_EXT_CLOCK];
    assign mode = mode_type'(timer_control_1[2:0]);
    assign batch_mode = (mode == mode_trigger_pulse) ||
                        (mode == mode_pwm);
    assign overflow_mode = (mode == mode_free_running) ||
                           (mode == mode_pulse_width);
    assign clear_on_match = !overflow_mode;
    assign access = psel & penable & pready & ce;
    assign wr_en = access & pwrite & addr_ok;

    // ****************************************************************
    // count clock selection
    // ****************************************************************
    // mask of low divider bits, divide by two to the select
    assign prescale_mask = 8'((9'h001 << timer_control_0[2:0]) - 9'h001);
    assign internal_tick = (prescale & prescale_mask) == prescale_mask;
    assign tick = timer_run_enable &
                  (external_clock_enable ? event_edge
                                         : internal_tick);

    // divider runs only while the timer runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 8'h00;
        end else if (ce) begin
            if (!timer_run_enable) begin
                prescale <= 8'h00;
            end else begin
                prescale <= prescale + 8'h01;
            end
        end
    end

    // edge of the shared input used for event counting
    timer16_edge_detect event_detect (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin(trigger_event_input),
        .edge_sel(event_trigger_edge_select[`POS_EVENT_EDGE +: 2]),
        .edge_seen(event_edge)
    );

    // edge of the same input used as capture trigger
    timer16_edge_detect capture_detect (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin(trigger_event_input),
        .edge_sel(capture_input_control[1:0]),
        .edge_seen(capture_edge)
    );

    // ****************************************************************
    // counter events
    // ****************************************************************
    assign start_tick = tick & !started;
    assign capture_clear = timer_run_enable & capture_edge &
                           (mode == mode_pulse_width);
    assign period_clear = tick & started & clear_on_match &
                          (counter == shadow[0]);
    // plain wrap is not a period clear, but a match at all-ones may coincide
    assign wrap = tick & started & !period_clear &
                  (counter == `COUNT_ALL_ONES);

    // per channel compare match, only after counting has begun
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_match
            // in the modes that clear on match, a shadow above the period value is never reached
            assign match[ch] = tick & started &
                               (counter == shadow[ch]);
        end
    endgenerate

    // ****************************************************************
    // sixteen-bit counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= `COUNT_ALL_ONES;
            started <= 1'b0;
        end else if (ce) begin
            if (!timer_run_enable) begin
                // stopped counter holds all-ones
                counter <= `COUNT_ALL_ONES;
                started <= 1'b0;
            end else if (capture_clear) begin
                counter <= `COUNT_ZERO;
            end else if (start_tick) begin
                // all-ones to zero in step with the count clock
                counter <= `COUNT_ZERO;
                started <= 1'b1;
            end else if (period_clear) begin
                counter <= `COUNT_ZERO;
            end else if (tick) begin
                counter <= counter + 16'h0001;
            end
        end
    end

    // note an all-ones capture; set a cycle late, so a wrap in the capture cycle still counts as an overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_ones <= 1'b0;
        end else if (ce) begin
            if (!timer_run_enable) begin
                captured_ones <= 1'b0;
            end else if (capture_clear) begin
                captured_ones <= (counter == `COUNT_ALL_ONES);
            end else if (tick) begin
                captured_ones <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // interrupt request pulses and overflow
    // ****************************************************************
    // one pclk pulse per event; mask is outside this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_match_irq <= 4'h0;
            overflow_irq <= 1'b0;
        end else if (ce) begin
            channel_match_irq <= match;
            overflow_irq <= wrap & overflow_mode &
                            !captured_ones;
        end
    end

    // sticky flag, set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag <= 1'b0;
        end else if (ce) begin
            if (wrap & overflow_mode & !captured_ones) begin
                overflow_flag <= 1'b1;
            end else if (wr_en && paddr == `OFS_OPTION_0 &&
                         !pwdata[`POS_OVERFLOW]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // shadow transfer
    // ****************************************************************
    // channel 1 write arms the batch; a write at transfer re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            batch_pending <= 1'b0;
        end else if (ce) begin
            if (wr_en && paddr == `OFS_COMPARE_BASE + 12'h004) begin
                batch_pending <= 1'b1;
            end else if (period_clear | !timer_run_enable) begin
                batch_pending <= 1'b0;
            end
        end
    end

    // shadows follow writes, or move together at the period match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                shadow[i] <= `RST_COMPARE;
            end
        end else if (ce) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                if (!timer_run_enable || start_tick) begin
                    shadow[i] <= compare_reg[i];
                end else if (!batch_mode) begin
                    shadow[i] <= compare_reg[i];
                end else if (period_clear & batch_pending) begin
                    shadow[i] <= compare_reg[i];
                end
            end
        end
    end

    // ****************************************************************
    // timer outputs
    // ****************************************************************
    // toggle flops restart from the idle level while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_state <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                if (!timer_run_enable) begin
                    toggle_state[i] <= timer_output_control[2 * i + 1];
                end else if (match[i] || (i == 0 && start_tick)) begin
                    toggle_state[i] <= !toggle_state[i];
                end
            end
        end
    end

    // pins show the toggle flop or the idle level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_output <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                timer_output[i] <= timer_output_control[2 * i] ?
                                   toggle_state[i] :
                                   timer_output_control[2 * i + 1];
            end
        end
    end

    // ****************************************************************
    // apb register writes
    // ****************************************************************
    // control and configuration bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_0 <= `RST_BYTE;
            timer_control_1 <= `RST_BYTE;
            timer_output_control <= `RST_BYTE;
            capture_input_control <= `RST_BYTE;
            event_trigger_edge_select <= `RST_BYTE;
        end else if (wr_en) begin
            unique case (paddr)
                `OFS_CONTROL_0: timer_control_0 <= pwdata[7:0];
                `OFS_CONTROL_1: timer_control_1 <= pwdata[7:0];
                `OFS_OUTPUT_CTRL: timer_output_control <= pwdata[7:0];
                `OFS_CAPTURE_CTRL: capture_input_control <= pwdata[7:0];
                `OFS_EDGE_SELECT: event_trigger_edge_select <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // compare words; a pulse-width capture lands in channel 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                compare_reg[i] <= `RST_COMPARE;
            end
        end else if (ce) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                if (i == 0 && capture_clear) begin
                    compare_reg[i] <= counter;
                end else if (wr_en && paddr == `OFS_COMPARE_BASE +
                             12'(4 * i)) begin
                    compare_reg[i] <= pwdata[15:0];
                end
            end
        end
    end

    // ****************************************************************
    // apb read and answer
    // ****************************************************************
    // read mux, unmapped addresses flagged
    always_comb begin
        next_rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            `OFS_CONTROL_0: next_rdata[7:0] = timer_control_0;
            `OFS_CONTROL_1: next_rdata[7:0] = timer_control_1;
            `OFS_OUTPUT_CTRL: next_rdata[7:0] = timer_output_control;
            `OFS_CAPTURE_CTRL: next_rdata[7:0] = capture_input_control;
            `OFS_EDGE_SELECT: next_rdata[7:0] = event_trigger_edge_select;
            `OFS_OPTION_0: next_rdata[`POS_OVERFLOW] = overflow_flag;
            `OFS_COMPARE_BASE: next_rdata[15:0] = compare_reg[0];
            `OFS_COMPARE_BASE + 12'h004: next_rdata[15:0] = compare_reg[1];
            `OFS_COMPARE_BASE + 12'h008: next_rdata[15:0] = compare_reg[2];
            `OFS_COMPARE_BASE + 12'h00C: next_rdata[15:0] = compare_reg[3];
            // live count while running, zero while stopped
            `OFS_COUNTER_READ: next_rdata[15:0] =
                timer_run_enable ? counter : `COUNT_ZERO;
            default: addr_ok = 1'b0;
        endcase
    end

    // one wait-free answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel & ~penable & ~pwrite) begin
                prdata <= next_rdata;
            end
        end
    end
endmodule

// >>> src/timer16_params.svh
// register offsets, field positions, reset values and counts of the timer
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define OFS_CONTROL_0 12'h000
`define OFS_CONTROL_1 12'h004
`define OFS_OUTPUT_CTRL 12'h008
`define OFS_CAPTURE_CTRL 12'h00C
`define OFS_EDGE_SELECT 12'h010
`define OFS_OPTION_0 12'h014
`define OFS_COMPARE_BASE 12'h018
`define OFS_COUNTER_READ 12'h028

// ****************************************************************
// field positions
// ****************************************************************
`define POS_RUN_ENABLE 7
`define POS_EXT_CLOCK 5
`define POS_OVERFLOW 0
`define POS_EVENT_EDGE 2

// ****************************************************************
// reset values and constants
// ****************************************************************
`define RST_BYTE 8'h00
`define RST_COMPARE 16'h0000
`define COUNT_ALL_ONES 16'hFFFF
`define COUNT_ZERO 16'h0000
`define NUM_CHANNELS 4

`endif

// >>> src/timer16_pkg.sv
// types shared by the timer design files
package timer16_pkg;

    // operating mode field of timer_control_1
    typedef enum logic [2:0] {
        mode_interval = 3'h0,
        mode_event_count = 3'h1,
        mode_trigger_pulse = 3'h2,
        mode_one_shot = 3'h3,
        mode_pwm = 3'h4,
        mode_free_running = 3'h5,
        mode_reserved = 3'h6,
        mode_pulse_width = 3'h7
    } mode_type;

    // edge choice: none, rising, falling, both
    typedef logic [1:0] edge_sel_type;

    // one counter word
    typedef logic [15:0] count_type;

endpackage

// >>> src/timer16_edge_detect.sv
// valid-edge detector for one timer input pin
module timer16_edge_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic pin,
    input wire timer16_pkg::edge_sel_type edge_sel,
    output logic edge_seen
);
    import timer16_pkg::*;

    // ****************************************************************
    // previous level and pulse
    // ****************************************************************
    logic pin_prev; // level one clock ago

    // remember the pin and flag the selected edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b0;
            edge_seen <= 1'b0;
        end else if (ce) begin
            pin_prev <= pin;
            edge_seen <= (edge_sel[0] & pin & ~pin_prev) |
                         (edge_sel[1] & ~pin & pin_prev);
        end
    end
endmodule

// >>> sim/timer16_core_sva.sv
// checker: bus and timer properties seen at the core's ports
`include "timer16_params.svh"
module timer16_core_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trigger_event_input,
    input wire logic [3:0] timer_output,
    input wire logic [3:0] channel_match_irq,
    input wire logic overflow_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // copies of written control fields
    // ********
    logic [7:0] oc; // output control
    logic run; // run enable
    logic [2:0] md; // mode field
    logic wr; // completed good write
    logic [3:0] idle; // idle level of each output
    logic [3:0] en; // enable of each output
    assign wr = psel && penable && pready && pwrite && !pslverr && ce;
    assign idle = {oc[7], oc[5], oc[3], oc[1]};
    assign en = {oc[6], oc[4], oc[2], oc[0]};
    // follow writes to the three control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc <= 8'h00;
            run <= 1'b0;
            md <= 3'h0;
        end else if (wr) begin
            // decode the written register
            if (paddr == `OFS_OUTPUT_CTRL) oc <= pwdata[7:0];
            if (paddr == `OFS_CONTROL_0) run <= pwdata[7];
            if (paddr == `OFS_CONTROL_1) md <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // properties
    // ********
    property p_answer;
        psel && !penable && ce |=> pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no ready after setup");
    property p_drop;
        pready |=> !pready;
    endproperty
    a_drop: assert property (p_drop)
        else $error("ready held too long");
    property p_map;
        pready |-> pslverr == (paddr > 12'h028 || paddr[1:0] != 2'h0);
    endproperty
    a_map: assert property (p_map)
        else $error("error flag wrong for address");
    property p_upper;
        pready && !pwrite |-> prdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    property p_stopbuf;
        pready && !pwrite && paddr == `OFS_COUNTER_READ && !run
            |-> prdata == 32'h0000_0000;
    endproperty
    a_stopbuf: assert property (p_stopbuf)
        else $error("stopped counter read not zero");
    property p_idle;
        ($stable(oc))[*3] |-> ((timer_output ^ idle) & ~en) == 4'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("disabled output not at idle level");
    property p_toggle;
        channel_match_irq[0] && oc[0] && $stable(oc)
            |-> ##[1:2] $changed(timer_output[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("output 0 did not toggle on match");
    property p_ovf;
        overflow_irq |-> md == 3'h5 || md == 3'h7;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow in a mode without overflow");
    property p_stop;
        (!run)[*3] |-> channel_match_irq == 4'h0 && !overflow_irq;
    endproperty
    a_stop: assert property (p_stop)
        else $error("request while stopped");
    c_match: cover property (channel_match_irq[0]);
    c_ovf: cover property (overflow_irq);
    c_err: cover property (pready && pslverr);
endmodule

// >>> sim/timer16_core_interval_mode_tb.sv
// testbench: register-level tests of the timer core
`include "timer16_params.svh"
`define CHK(nm, e, v) \
    begin \
        comparisons++; \
        if ((v) !== (e)) begin \
            n_errors++; \
            $display("wrong value %s expected %h seen %h", nm, e, v); \
        end \
    end
module timer16_core_interval_mode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] timer_output;
    logic [3:0] channel_match_irq;
    logic overflow_irq;
    logic trigger_event_input = 1'b0; // shared event and capture pin
    logic [31:0] rd; // last read data
    logic er; // last error flag
    int n_errors = 0;
    int comparisons = 0;
    int g; // measured gap
    int n; // cycle count
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    timer16_core i_timer16_core (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_event_input(trigger_event_input),
        .timer_output(timer_output),
        .channel_match_irq(channel_match_irq),
        .overflow_irq(overflow_irq)
    );
    // ********
    // bus and timing tasks
    // ********
    // one transfer: setup, access until ready
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles between two match pulses of channel k
    task automatic gap(input int k);
        n = 0;
        while (channel_match_irq[k] !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        g = 1;
        while (channel_match_irq[k] !== 1'b1 && g < 3000) begin
            @(posedge pclk);
            g++;
        end
    endtask
    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        final_report();
    end
    // ********
    // test sequence
    // ********
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(`OFS_COUNTER_READ, 1'b0, 32'h0);
        `CHK("idle count", 32'h0, rd)
        xfer(`OFS_OUTPUT_CTRL, 1'b0, 32'h0);
        `CHK("out ctrl reset", 32'h0, rd)
        xfer(12'h02C, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        xfer(`OFS_OUTPUT_CTRL, 1'b1, 32'hAA);
        repeat (3) @(posedge pclk);
        `CHK("idle high", 4'hF, timer_output)
        // interval mode, period 3, channel 2 beyond period
        xfer(`OFS_OUTPUT_CTRL, 1'b1, 32'h01);
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h2);
        xfer(`OFS_COMPARE_BASE + 12'h4, 1'b1, 32'h1);
        xfer(`OFS_COMPARE_BASE + 12'h8, 1'b1, 32'h5);
        xfer(`OFS_CONTROL_1, 1'b1, 32'h0);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        gap(0);
        `CHK("period", 3, g)
        gap(1);
        `CHK("ch1 period", 3, g)
        n = 0;
        repeat (40) begin
            @(posedge pclk);
            if (channel_match_irq[2] !== 1'b0) n++;
        end
        `CHK("ch2 pulses", 0, n)
        xfer(`OFS_COUNTER_READ, 1'b0, 32'h0);
        `CHK("live count", 1'b1, rd[15:0] <= 16'h2)
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h5);
        gap(0);
        gap(0);
        `CHK("written period", 6, g)
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        xfer(`OFS_COUNTER_READ, 1'b0, 32'h0);
        `CHK("stopped count", 32'h0, rd)
        // prescaler by two, then compare zero
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h2);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h81);
        gap(0);
        `CHK("prescaled", 6, g)
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h0);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        gap(0);
        `CHK("compare zero", 1, g)
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        // batch write in pwm mode
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h2);
        xfer(`OFS_CONTROL_1, 1'b1, 32'h4);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        xfer(`OFS_COMPARE_BASE, 1'b1, 32'h5);
        gap(0);
        gap(0);
        `CHK("held period", 3, g)
        xfer(`OFS_COMPARE_BASE + 12'h4, 1'b1, 32'h1);
        gap(0);
        gap(0);
        `CHK("batch period", 6, g)
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        // event count mode, period 2, rising edges of the pin
        xfer(`OFS_CAPTURE_CTRL, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++)
            xfer(`OFS_COMPARE_BASE + 12'(4 * i), 1'b1, 32'h1);
        xfer(`OFS_EDGE_SELECT, 1'b1, 32'h4);
        for (int i = 0; i < 4; i++)
            xfer(`OFS_COMPARE_BASE + 12'(4 * i), 1'b1, 32'h1);
        xfer(`OFS_CONTROL_1, 1'b1, 32'h21);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        n = 0;
        // five rising edges: start, then two full periods
        for (int i = 0; i < 44; i++) begin
            @(posedge pclk);
            trigger_event_input <= i[2] && i < 40;
            if (channel_match_irq[0] === 1'b1) n++;
        end
        `CHK("event matches", 2, n)
        // pulse width: a rising capture edge stores and clears the count
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        xfer(`OFS_CONTROL_1, 1'b1, 32'h7);
        xfer(`OFS_CAPTURE_CTRL, 1'b1, 32'h1);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        repeat (10) @(posedge pclk);
        trigger_event_input <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer(`OFS_COMPARE_BASE, 1'b0, 32'h0);
        `CHK("captured", 32'hA, rd)
        xfer(`OFS_COUNTER_READ, 1'b0, 32'h0);
        `CHK("cleared", 1'b1, rd[15:0] < 16'hA)
        xfer(`OFS_CONTROL_0, 1'b1, 32'h0);
        // free-running overflow
        xfer(`OFS_CONTROL_1, 1'b1, 32'h5);
        xfer(`OFS_CONTROL_0, 1'b1, 32'h80);
        n = 0;
        while (overflow_irq !== 1'b1 && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        `CHK("wrap span", 1'b1, n > 65500 && n < 65600)
        xfer(`OFS_OPTION_0, 1'b0, 32'h0);
        `CHK("ovf flag", 32'h1, rd)
        xfer(`OFS_OPTION_0, 1'b1, 32'h0);
        xfer(`OFS_OPTION_0, 1'b0, 32'h0);
        `CHK("ovf cleared", 32'h0, rd)
        final_report();
    end
endmodule
bind timer16_core timer16_core_sva i_timer16_core_sva (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_event_input(trigger_event_input),
    .timer_output(timer_output),
    .channel_match_irq(channel_match_irq),
    .overflow_irq(overflow_irq)
);
